//--- frame_rx_filter_pkg.sv
// constants for the receive frame filter and phy control block
// Behaviour
// - with auto checksum on, last 2 or 4 sent octets of a frame longer than that carry computed checksum
// - phy control bit 4 enables auto transmit checksum, reset value 1
// - phy control bit 3 selects checksum type: 0 is 32-bit, 1 is 16-bit
// - phy control bit 2 switches the baseband on, reset value 1
// - phy control bits 1:0 select phy kind, reset value 0
// - frame-end event only when every enabled filter passes
// - checksum filter on rejects bad checksum; off passes every frame
// - promiscuous mode passes second level; otherwise address filter applies if enabled
// - address filter counts as enabled when any of four unit enables is set
// - global filter needs frame kind and version selected in their masks
// - present destination pan must equal unit pan or broadcast pan
// - short destination equals unit short or broadcast; extended equals device address
// - beacon source pan equals unit pan unless unit pan is broadcast
// - source-only data or command frame needs coordinator and matching source pan
// - third level also needs non-acknowledge kind and at least one address
// - address-match event when global and one enabled unit's rules pass
// - extended-match event for address filter enabled, global pass plus any extended condition
// - four independent units with own settings; status shows which matched
// - one extended address shared by all four units
// - frame-start event on valid header, before any address filtering
// - checksum good clears at frame start, updates at frame end
// - match status bits update once the header is fully parsed
package frame_rx_filter_pkg;
  localparam int         UNITS          = 4;
  localparam int         LEN_W          = 11;
  localparam logic [7:0] OFS_PHY_CTL    = 8'h00;
  localparam logic [7:0] OFS_FILT_CTL   = 8'h01;
  localparam logic [7:0] OFS_KIND_MASK  = 8'h02;
  localparam logic [7:0] OFS_VER_MASK   = 8'h03;
  localparam logic [7:0] OFS_UNIT_CFG   = 8'h04;
  localparam logic [7:0] OFS_HIT_STAT   = 8'h05;
  localparam logic [7:0] OFS_EXT_ADDR   = 8'h08;
  localparam logic [7:0] OFS_UNIT_ADDR  = 8'h10;
  localparam int         PC_CONT_TX     = 7;
  localparam int         PC_FILT_EN     = 6;
  localparam int         PC_CSUM_GOOD   = 5;
  localparam int         PC_AUTO_CSUM   = 4;
  localparam int         PC_CSUM_TYPE   = 3;
  localparam int         PC_BB_ON       = 2;
  localparam int         PC_KIND_LO     = 0;
  localparam logic [7:0] PHY_CTL_RESET  = 8'h54;
  localparam logic [7:0] KIND_MASK_RESET = 8'h0B;
  localparam logic [3:0] VER_MASK_RESET = 4'h3;
  localparam logic [15:0] BCAST_ID      = 16'hFFFF;
  localparam logic [2:0] CSUM_LEN_32    = 3'h4;
  localparam logic [2:0] CSUM_LEN_16    = 3'h2;
  localparam logic [2:0] KIND_BEACON    = 3'h0;
  localparam logic [2:0] KIND_DATA      = 3'h1;
  localparam logic [2:0] KIND_ACK       = 3'h2;
  localparam logic [2:0] KIND_CMD       = 3'h3;
  localparam logic [1:0] AMODE_NONE     = 2'h0;
  localparam logic [1:0] AMODE_RSVD     = 2'h1;
  localparam logic [1:0] AMODE_SHORT    = 2'h2;
  localparam logic [1:0] AMODE_EXT      = 2'h3;

  typedef enum logic [1:0] {
    PHY_OFF   = 2'b00,
    PHY_FSK   = 2'b01,
    PHY_OFDM  = 2'b10,
    PHY_OQPSK = 2'b11
  } phy_kind_t;
endpackage : frame_rx_filter_pkg

//--- addr_unit.sv
// one third-level address filter unit
`timescale 1ns/1ps
module addr_unit
  import frame_rx_filter_pkg::*;
(
  input  wire logic        unit_en,
  input  wire logic [15:0] unit_short,
  input  wire logic [15:0] unit_pan,
  input  wire logic        pan_coordinator_sel,
  input  wire logic        reserved_kind_map,
  input  wire logic [63:0] ext_addr,
  input  wire logic [2:0]  hdr_kind,
  input  wire logic [1:0]  hdr_dst_mode,
  input  wire logic [1:0]  hdr_src_mode,
  input  wire logic [15:0] hdr_dst_pan,
  input  wire logic [15:0] hdr_src_pan,
  input  wire logic [63:0] hdr_dst_addr,
  output wire logic        unit_match
);
  wire       is_rsvd   = hdr_kind[2];
  wire [2:0] eff_kind  = (is_rsvd && reserved_kind_map) ? KIND_DATA : hdr_kind;
  wire       kind_ok   = !is_rsvd || reserved_kind_map;
  wire       dst_there = hdr_dst_mode != AMODE_NONE;
  wire       src_there = hdr_src_mode != AMODE_NONE;
  wire       dpan_ok   = !dst_there || hdr_dst_pan == unit_pan || hdr_dst_pan == BCAST_ID;
  wire       short_ok  = hdr_dst_addr[15:0] == unit_short || hdr_dst_addr[15:0] == BCAST_ID;
  wire       ext_ok    = hdr_dst_addr == ext_addr;
  wire       daddr_ok  = (hdr_dst_mode == AMODE_SHORT) ? short_ok :
                         (hdr_dst_mode == AMODE_EXT) ? ext_ok : 1'b1;
  wire       beacon_ok = eff_kind != KIND_BEACON || unit_pan == BCAST_ID
                         || hdr_src_pan == unit_pan;
  wire       src_only  = !dst_there && src_there && (eff_kind == KIND_DATA || eff_kind == KIND_CMD);
  wire       srco_ok   = !src_only || (pan_coordinator_sel && hdr_src_pan == unit_pan);
  wire       extra_ok  = eff_kind != KIND_ACK && (dst_there || src_there);

  assign unit_match = unit_en && kind_ok && dpan_ok && daddr_ok && beacon_ok && srco_ok && extra_ok;
endmodule : addr_unit

//--- frame_rx_filter.sv
// receive frame filter, phy control register and transmit checksum insertion
`timescale 1ns/1ps
module frame_rx_filter
  import frame_rx_filter_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic        ce,
  // host register port
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  output logic             reg_rvalid,
  // receive side events from the demodulator and header parser
  input  wire logic        rx_hdr_valid,
  input  wire logic        mac_hdr_done,
  input  wire logic [2:0]  hdr_kind,
  input  wire logic [1:0]  hdr_version,
  input  wire logic [1:0]  hdr_dst_mode,
  input  wire logic [1:0]  hdr_src_mode,
  input  wire logic [15:0] hdr_dst_pan,
  input  wire logic [15:0] hdr_src_pan,
  input  wire logic [63:0] hdr_dst_addr,
  input  wire logic        rx_frame_done,
  input  wire logic        rx_checksum_ok,
  // transmit byte stream
  input  wire logic        tx_in_valid,
  input  wire logic [7:0]  tx_in_byte,
  input  wire logic [frame_rx_filter_pkg::LEN_W-1:0] tx_in_index,
  input  wire logic [frame_rx_filter_pkg::LEN_W-1:0] tx_frame_len,
  input  wire logic [31:0] tx_checksum,
  output logic             tx_out_valid,
  output logic      [7:0]  tx_out_byte,
  // events and configuration outputs
  output logic             rx_frame_start_irq,
  output logic             rx_addr_match_irq,
  output logic             rx_ext_match_irq,
  output logic             rx_frame_end_irq,
  output logic             baseband_on,
  output logic      [1:0]  phy_kind_sel,
  output logic             checksum_type_sel,
  output logic             cont_tx
);
  import frame_rx_filter_pkg::*;

  // configuration and status storage
  logic [7:0]  phy_control;
  logic        promisc_sel;
  logic [3:0]  addr_unit_en;
  logic [7:0]  frame_kind_mask;
  logic [3:0]  frame_version_mask;
  logic [3:0]  pan_coordinator_sel;
  logic [3:0]  reserved_kind_map;
  logic [63:0] ext_addr;
  logic [15:0] unit_short [UNITS];
  logic [15:0] unit_pan   [UNITS];
  logic [3:0]  addr_unit_hit_status;
  logic        addr_match;
  logic        ext_match;
  logic        checksum_good;
  logic        in_frame;

  // field views of phy control
  wire       tx_auto_checksum   = phy_control[PC_AUTO_CSUM];
  wire       checksum_filter_en = phy_control[PC_FILT_EN];
  wire       csum_type_16       = phy_control[PC_CSUM_TYPE];
  wire       bb_enabled         = phy_control[PC_BB_ON];
  wire [1:0] phy_kind_field     = phy_control[PC_KIND_LO +: 2];

  // write decode
  wire       wr_phy    = reg_wr && reg_addr == OFS_PHY_CTL;
  wire       wr_filt   = reg_wr && reg_addr == OFS_FILT_CTL;
  wire       wr_kind   = reg_wr && reg_addr == OFS_KIND_MASK;
  wire       wr_ver    = reg_wr && reg_addr == OFS_VER_MASK;
  wire       wr_ucfg   = reg_wr && reg_addr == OFS_UNIT_CFG;
  wire       wr_ext    = reg_wr && reg_addr[7:3] == OFS_EXT_ADDR[7:3];
  wire       wr_uaddr  = reg_wr && reg_addr[7:4] == OFS_UNIT_ADDR[7:4];
  wire [1:0] uaddr_sel = reg_addr[3:2];
  wire [1:0] ufield    = reg_addr[1:0];

  // filter evaluation on the parsed header
  wire        rx_active   = bb_enabled && phy_kind_field != PHY_OFF;
  wire        af_enabled  = |addr_unit_en;
  wire        kind_sel_ok = frame_kind_mask[hdr_kind];
  wire        ver_sel_ok  = frame_version_mask[hdr_version];
  wire        global_ok   = kind_sel_ok && ver_sel_ok;
  wire [3:0]  unit_hit;
  wire        any_unit    = |unit_hit;
  wire        ext_cond    = hdr_kind[2] || hdr_version[1] || hdr_src_mode == AMODE_RSVD
                            || (hdr_kind != KIND_BEACON && hdr_dst_mode == AMODE_RSVD);
  wire        next_am     = af_enabled && global_ok && any_unit;
  wire        next_em     = af_enabled && global_ok && ext_cond;
  wire        hdr_take    = ce && mac_hdr_done && in_frame && rx_active;
  wire        start_take  = ce && rx_hdr_valid && rx_active;
  wire        end_take    = ce && rx_frame_done && in_frame && rx_active;

  // frame end qualification
  wire        level1_ok   = !checksum_filter_en || rx_checksum_ok;
  wire        level2_ok   = promisc_sel || !af_enabled || addr_match || ext_match;
  wire        next_fe     = level1_ok && level2_ok;

  genvar gi;
  generate
    for (gi = 0; gi < UNITS; gi++) begin : g_unit
      addr_unit u_unit (
        .unit_en             (addr_unit_en[gi]),
        .unit_short          (unit_short[gi]),
        .unit_pan            (unit_pan[gi]),
        .pan_coordinator_sel (pan_coordinator_sel[gi]),
        .reserved_kind_map   (reserved_kind_map[gi]),
        .ext_addr            (ext_addr),
        .hdr_kind            (hdr_kind),
        .hdr_dst_mode        (hdr_dst_mode),
        .hdr_src_mode        (hdr_src_mode),
        .hdr_dst_pan         (hdr_dst_pan),
        .hdr_src_pan         (hdr_src_pan),
        .hdr_dst_addr        (hdr_dst_addr),
        .unit_match          (unit_hit[gi])
      );

      // per-unit address registers, low byte first
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          unit_short[gi] <= BCAST_ID;
          unit_pan[gi]   <= BCAST_ID;
        end else if (ce && wr_uaddr && uaddr_sel == 2'(gi)) begin
          unique case (ufield)
            2'h0: unit_short[gi][7:0]  <= reg_wdata;
            2'h1: unit_short[gi][15:8] <= reg_wdata;
            2'h2: unit_pan[gi][7:0]    <= reg_wdata;
            2'h3: unit_pan[gi][15:8]   <= reg_wdata;
          endcase
        end
      end
    end
  endgenerate

  // read mux
  wire [15:0] rd_unit_word = ufield[1] ? unit_pan[uaddr_sel] : unit_short[uaddr_sel];
  wire [7:0]  rd_unit_byte = ufield[0] ? rd_unit_word[15:8] : rd_unit_word[7:0];
  wire [7:0]  rd_ext_byte  = ext_addr[{reg_addr[2:0], 3'h0} +: 8];
  wire [7:0]  rd_phy       = {phy_control[7:6], checksum_good, phy_control[4:0]};
  wire [7:0]  next_rdata   =
    (reg_addr == OFS_PHY_CTL)               ? rd_phy :
    (reg_addr == OFS_FILT_CTL)              ? {3'h0, addr_unit_en, promisc_sel} :
    (reg_addr == OFS_KIND_MASK)             ? frame_kind_mask :
    (reg_addr == OFS_VER_MASK)              ? {4'h0, frame_version_mask} :
    (reg_addr == OFS_UNIT_CFG)              ? {reserved_kind_map, pan_coordinator_sel} :
    (reg_addr == OFS_HIT_STAT)              ? {2'h0, ext_match, addr_match, addr_unit_hit_status} :
    (reg_addr[7:3] == OFS_EXT_ADDR[7:3])    ? rd_ext_byte :
    (reg_addr[7:4] == OFS_UNIT_ADDR[7:4])   ? rd_unit_byte :
                                              8'h00;

  // transmit checksum insertion
  wire [2:0]       csum_len   = csum_type_16 ? CSUM_LEN_16 : CSUM_LEN_32;
  wire [LEN_W-1:0] tail_start = tx_frame_len - LEN_W'(csum_len);
  wire             in_tail    = tx_in_index >= tail_start && tx_in_index < tx_frame_len;
  wire [LEN_W-1:0] tail_pos   = tx_in_index - tail_start;
  wire [7:0]       csum_byte  = tx_checksum[{tail_pos[1:0], 3'h0} +: 8];
  wire             do_insert  = tx_auto_checksum && tx_frame_len > LEN_W'(csum_len) && in_tail;
  wire [7:0]       next_tx    = do_insert ? csum_byte : tx_in_byte;

  // phy control register, checksum good kept separately
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      phy_control <= PHY_CTL_RESET;
    end else if (ce && wr_phy) begin
      phy_control <= reg_wdata;
    end
  end

  // filter configuration registers
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      promisc_sel         <= 1'b0;
      addr_unit_en        <= 4'h0;
      frame_kind_mask     <= KIND_MASK_RESET;
      frame_version_mask  <= VER_MASK_RESET;
      pan_coordinator_sel <= 4'h0;
      reserved_kind_map   <= 4'h0;
    end else if (ce) begin
      if (wr_filt) begin
        promisc_sel  <= reg_wdata[0];
        addr_unit_en <= reg_wdata[4:1];
      end
      if (wr_kind) begin
        frame_kind_mask <= reg_wdata;
      end
      if (wr_ver) begin
        frame_version_mask <= reg_wdata[3:0];
      end
      if (wr_ucfg) begin
        pan_coordinator_sel <= reg_wdata[3:0];
        reserved_kind_map   <= reg_wdata[7:4];
      end
    end
  end

  // shared extended address, low byte at the lowest offset
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      ext_addr <= 64'h0;
    end else if (ce && wr_ext) begin
      ext_addr[{reg_addr[2:0], 3'h0} +: 8] <= reg_wdata;
    end
  end

  // read data
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      reg_rdata  <= 8'h00;
      reg_rvalid <= 1'b0;
    end else if (ce) begin
      reg_rvalid <= reg_rd;
      if (reg_rd) begin
        reg_rdata <= next_rdata;
      end
    end
  end

  // frame tracking and checksum verdict
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      in_frame      <= 1'b0;
      checksum_good <= 1'b0;
    end else if (ce) begin
      if (start_take) begin
        in_frame      <= 1'b1;
        checksum_good <= 1'b0;
      end else if (end_take) begin
        in_frame      <= 1'b0;
        checksum_good <= rx_checksum_ok;
      end else if (!rx_active) begin
        in_frame      <= 1'b0;
      end
    end
  end

  // match status, cleared at frame start and loaded after header parse
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      addr_match           <= 1'b0;
      ext_match            <= 1'b0;
      addr_unit_hit_status <= 4'h0;
    end else if (ce) begin
      if (start_take) begin
        addr_match           <= 1'b0;
        ext_match            <= 1'b0;
        addr_unit_hit_status <= 4'h0;
      end else if (hdr_take) begin
        addr_match           <= next_am;
        ext_match            <= next_em;
        addr_unit_hit_status <= global_ok ? unit_hit : 4'h0;
      end
    end
  end

  // one-cycle event pulses
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rx_frame_start_irq <= 1'b0;
      rx_addr_match_irq  <= 1'b0;
      rx_ext_match_irq   <= 1'b0;
      rx_frame_end_irq   <= 1'b0;
    end else if (ce) begin
      rx_frame_start_irq <= start_take;
      rx_addr_match_irq  <= hdr_take && next_am;
      rx_ext_match_irq   <= hdr_take && next_em;
      rx_frame_end_irq   <= end_take && next_fe;
    end
  end

  // transmit stream, one cycle of latency
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tx_out_valid <= 1'b0;
      tx_out_byte  <= 8'h00;
    end else if (ce) begin
      tx_out_valid <= tx_in_valid;
      if (tx_in_valid) begin
        tx_out_byte <= next_tx;
      end
    end
  end

  // registered configuration outputs
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      baseband_on       <= PHY_CTL_RESET[PC_BB_ON];
      phy_kind_sel      <= PHY_CTL_RESET[PC_KIND_LO +: 2];
      checksum_type_sel <= PHY_CTL_RESET[PC_CSUM_TYPE];
      cont_tx           <= PHY_CTL_RESET[PC_CONT_TX];
    end else if (ce) begin
      baseband_on       <= bb_enabled;
      phy_kind_sel      <= phy_kind_field;
      checksum_type_sel <= csum_type_16;
      cont_tx           <= phy_control[PC_CONT_TX];
    end
  end
endmodule : frame_rx_filter

//--- frame_rx_filter_asserts.sv
// port assertions for the receive frame filter
`timescale 1ns/1ps
module frame_rx_filter_asserts (
  input wire logic                                  clk_sys,
  input wire logic                                  rst,
  input wire logic                                  reg_rd,
  input wire logic                                  reg_rvalid,
  input wire logic                                  rx_hdr_valid,
  input wire logic                                  mac_hdr_done,
  input wire logic [2:0]                            hdr_kind,
  input wire logic [1:0]                            hdr_version,
  input wire logic [1:0]                            hdr_dst_mode,
  input wire logic [1:0]                            hdr_src_mode,
  input wire logic                                  rx_frame_done,
  input wire logic                                  tx_in_valid,
  input wire logic [7:0]                            tx_in_byte,
  input wire logic [frame_rx_filter_pkg::LEN_W-1:0] tx_in_index,
  input wire logic [frame_rx_filter_pkg::LEN_W-1:0] tx_frame_len,
  input wire logic                                  tx_out_valid,
  input wire logic [7:0]                            tx_out_byte,
  input wire logic                                  rx_frame_start_irq,
  input wire logic                                  rx_addr_match_irq,
  input wire logic                                  rx_ext_match_irq,
  input wire logic                                  rx_frame_end_irq,
  input wire logic                                  baseband_on,
  input wire logic [1:0]                            phy_kind_sel
);
  import frame_rx_filter_pkg::*;
  logic ext_cause;
  // header carried one of the extended conditions
  always_ff @(posedge clk_sys) begin
    ext_cause <= mac_hdr_done && (hdr_kind >= 3'h4 || hdr_version >= 2'h2 || hdr_src_mode == AMODE_RSVD
                 || (hdr_kind != KIND_BEACON && hdr_dst_mode == AMODE_RSVD));
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence tx_short_s;
    tx_in_valid && tx_frame_len <= 11'h002;
  endsequence
  sequence tx_head_s;
    tx_in_valid && ({1'b0, tx_in_index} + 12'h004 < {1'b0, tx_frame_len});
  endsequence
  start_cause_a: assert property (rx_frame_start_irq |-> $past(rx_hdr_valid))
    else $error("start event without header");
  am_hdr_a: assert property (rx_addr_match_irq |-> $past(mac_hdr_done))
    else $error("address match outside header end");
  am_ack_a: assert property (rx_addr_match_irq |-> $past(hdr_kind) != KIND_ACK)
    else $error("address match on acknowledge");
  ext_cause_a: assert property (rx_ext_match_irq |-> ext_cause)
    else $error("extended match without cause");
  end_cause_a: assert property (rx_frame_end_irq |-> $past(rx_frame_done))
    else $error("frame end without frame done");
  tx_valid_a: assert property (tx_in_valid |=> tx_out_valid)
    else $error("transmit byte lost");
  tx_short_a: assert property (tx_short_s |=> tx_out_byte == $past(tx_in_byte))
    else $error("short frame byte altered");
  tx_head_a: assert property (tx_head_s |=> tx_out_byte == $past(tx_in_byte))
    else $error("head byte altered");
  reset_vals_a: assert property ($fell(rst) |-> baseband_on && phy_kind_sel == 2'h0)
    else $error("phy outputs wrong after reset");
  read_answer_a: assert property (reg_rd |=> reg_rvalid)
    else $error("read not answered");
endmodule : frame_rx_filter_asserts
bind frame_rx_filter frame_rx_filter_asserts u_chk (.clk_sys, .rst, .reg_rd, .reg_rvalid, .rx_hdr_valid,
  .mac_hdr_done, .hdr_kind, .hdr_version, .hdr_dst_mode, .hdr_src_mode, .rx_frame_done, .tx_in_valid,
  .tx_in_byte, .tx_in_index, .tx_frame_len, .tx_out_valid, .tx_out_byte, .rx_frame_start_irq,
  .rx_addr_match_irq, .rx_ext_match_irq, .rx_frame_end_irq, .baseband_on, .phy_kind_sel);

//--- host_model.sv
// host controller model on the register port
`timescale 1ns/1ps
module host_model (
  input  wire logic       clk_sys,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic      [7:0] reg_addr,
  output logic      [7:0] reg_wdata,
  input  wire logic [7:0] reg_rdata,
  input  wire logic       reg_rvalid
);
  initial begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end
  // writes only while no automatic procedure runs
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge clk_sys);
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(negedge clk_sys);
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    int i;
    @(negedge clk_sys);
    reg_rd = 1'b1;
    reg_addr = a;
    @(negedge clk_sys);
    reg_rd = 1'b0;
    reg_addr = ~a;
    i = 0;
    while (reg_rvalid !== 1'b1 && i < 4) begin
      @(negedge clk_sys);
      i++;
    end
    d = (i < 4) ? reg_rdata : 8'hXX;
  endtask : rd
endmodule : host_model

//--- tb_top.sv
// self-checking bench for the receive frame filter
`timescale 1ns/1ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin n_fail++; $display("Error t=%0t got %h exp %h", $time, g, e); end end
module tb_top;
  import frame_rx_filter_pkg::*;
  localparam logic [31:0] CKS = 32'h44332211;
  int n_fail = 0;
  int n_compared = 0;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic reg_wr, reg_rd, reg_rvalid, tx_out_valid, baseband_on, checksum_type_sel, cont_tx;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, tx_out_byte;
  logic rx_frame_start_irq, rx_addr_match_irq, rx_ext_match_irq, rx_frame_end_irq;
  logic [1:0] phy_kind_sel;
  logic rx_hdr_valid = 1'b0, mac_hdr_done = 1'b0, rx_frame_done = 1'b0, rx_checksum_ok = 1'b0;
  logic [2:0] hdr_kind = 3'h0;
  logic [1:0] hdr_version = 2'h0, hdr_dst_mode = 2'h0, hdr_src_mode = 2'h0;
  logic [15:0] hdr_dst_pan = 16'h0000, hdr_src_pan = 16'h0000;
  logic [63:0] hdr_dst_addr = 64'h0;
  logic tx_in_valid = 1'b0;
  logic [7:0] tx_in_byte = 8'h00;
  logic [10:0] tx_in_index = 11'h000, tx_frame_len = 11'h000;
  logic [31:0] tx_checksum = CKS;
  always #2.5 clk_sys = ~clk_sys;
  host_model host (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata, .reg_rvalid);
  frame_rx_filter dut (.clk_sys, .rst, .ce(1'b1), .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
    .reg_rvalid, .rx_hdr_valid, .mac_hdr_done, .hdr_kind, .hdr_version, .hdr_dst_mode, .hdr_src_mode,
    .hdr_dst_pan, .hdr_src_pan, .hdr_dst_addr, .rx_frame_done, .rx_checksum_ok, .tx_in_valid, .tx_in_byte,
    .tx_in_index, .tx_frame_len, .tx_checksum, .tx_out_valid, .tx_out_byte, .rx_frame_start_irq,
    .rx_addr_match_irq, .rx_ext_match_irq, .rx_frame_end_irq, .baseband_on, .phy_kind_sel,
    .checksum_type_sel, .cont_tx);
  task automatic print_verdict;
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : print_verdict
  task automatic rchk(input logic [7:0] a, e);
    logic [7:0] d;
    host.rd(a, d);
    `CHK(d, e)
  endtask : rchk
  // r: checksum ok, address match, extended match, frame end
  task automatic frame(input logic [2:0] k, input logic [1:0] v, dm, sm, input logic [15:0] dp, sp,
                       input logic [63:0] da, input logic [3:0] r);
    @(negedge clk_sys);
    rx_hdr_valid = 1'b1;
    @(negedge clk_sys);
    rx_hdr_valid = 1'b0;
    `CHK(rx_frame_start_irq, 1'b1)
    {hdr_kind, hdr_version, hdr_dst_mode, hdr_src_mode} = {k, v, dm, sm};
    {hdr_dst_pan, hdr_src_pan, hdr_dst_addr} = {dp, sp, da};
    mac_hdr_done = 1'b1;
    @(negedge clk_sys);
    mac_hdr_done = 1'b0;
    `CHK({rx_addr_match_irq, rx_ext_match_irq}, r[2:1])
    rx_frame_done = 1'b1;
    rx_checksum_ok = r[3];
    @(negedge clk_sys);
    rx_frame_done = 1'b0;
    `CHK(rx_frame_end_irq, r[0])
  endtask : frame
  // data frame, short destination, no source
  task automatic dsh(input logic [1:0] v, input logic [15:0] dp, input logic [63:0] da, input logic [3:0] r);
    frame(KIND_DATA, v, AMODE_SHORT, AMODE_NONE, dp, 16'h0, da, r);
  endtask : dsh
  // insertion only on frames longer than the checksum
  task automatic txf(input int len, input logic t16, input logic auto_on);
    int n;
    logic [7:0] e;
    n = t16 ? 2 : 4;
    host.wr(OFS_PHY_CTL, {3'b010, auto_on, t16, 3'b111});
    tx_frame_len = len[10:0];
    for (int i = 0; i <= len; i++) begin
      @(negedge clk_sys);
      if (i > 0) begin
        `CHK({tx_out_valid, tx_out_byte}, {1'b1, e})
      end
      e = (auto_on && len > n && i >= len - n) ? CKS[8*(i-len+n) +: 8] : 8'hA0 + i[7:0];
      tx_in_valid = (i < len);
      tx_in_byte = 8'hA0 + i[7:0];
      tx_in_index = i[10:0];
    end
  endtask : txf
  task automatic t_reset;
    `CHK({baseband_on, phy_kind_sel, checksum_type_sel, cont_tx}, 5'b10000)
    rchk(OFS_PHY_CTL, PHY_CTL_RESET);
    rchk(8'h06, 8'h00);
    host.wr(OFS_PHY_CTL, 8'hFF);
    rchk(OFS_PHY_CTL, 8'hDF);
    `CHK(cont_tx, 1'b1)
  endtask : t_reset
  task automatic t_phy;
    for (int k = 0; k < 4; k++) begin
      host.wr(OFS_PHY_CTL, {4'b0101, k[0], 1'b1, k[1:0]});
      @(negedge clk_sys);
      `CHK({checksum_type_sel, phy_kind_sel}, {k[0], k[1:0]})
      rchk(OFS_PHY_CTL, {4'b0101, k[0], 1'b1, k[1:0]});
    end
    host.wr(OFS_PHY_CTL, 8'h53);
    @(negedge clk_sys);
    `CHK(baseband_on, 1'b0)
    rx_hdr_valid = 1'b1;
    @(negedge clk_sys);
    rx_hdr_valid = 1'b0;
    `CHK(rx_frame_start_irq, 1'b0)
    host.wr(OFS_PHY_CTL, 8'h57);
  endtask : t_phy
  task automatic t_level1;
    dsh(2'h0, 16'h1, 64'h1, 4'b0000);
    dsh(2'h0, 16'h1, 64'h1, 4'b1001);
    rchk(OFS_PHY_CTL, 8'h77);
    @(negedge clk_sys);
    rx_hdr_valid = 1'b1;
    @(negedge clk_sys);
    rx_hdr_valid = 1'b0;
    rchk(OFS_PHY_CTL, 8'h57);
    host.wr(OFS_PHY_CTL, 8'h17);
    dsh(2'h0, 16'h1, 64'h1, 4'b0001);
    host.wr(OFS_PHY_CTL, 8'h57);
  endtask : t_level1
  task automatic t_units;
    host.wr(8'h14, 8'h34);
    host.wr(8'h15, 8'h12);
    host.wr(8'h16, 8'hCD);
    host.wr(8'h17, 8'hAB);
    host.wr(OFS_EXT_ADDR, 8'h5A);
    host.wr(OFS_FILT_CTL, 8'h06);
    dsh(2'h0, 16'hABCD, 64'h1234, 4'b1101);
    rchk(OFS_HIT_STAT, 8'h12);
    dsh(2'h0, 16'h1111, 64'h1234, 4'b1000);
    dsh(2'h0, 16'hFFFF, 64'hFFFF, 4'b1101);
    rchk(OFS_HIT_STAT, 8'h13);
    frame(KIND_BEACON, 2'h0, AMODE_NONE, AMODE_SHORT, 16'h0, 16'h1111, 64'h0, 4'b1101);
    host.wr(OFS_FILT_CTL, 8'h04);
    frame(KIND_BEACON, 2'h0, AMODE_NONE, AMODE_SHORT, 16'h0, 16'h1111, 64'h0, 4'b1000);
    frame(KIND_BEACON, 2'h0, AMODE_NONE, AMODE_SHORT, 16'h0, 16'hABCD, 64'h0, 4'b1101);
    frame(KIND_DATA, 2'h0, AMODE_EXT, AMODE_NONE, 16'hABCD, 16'h0, 64'h5A, 4'b1101);
    frame(KIND_DATA, 2'h0, AMODE_EXT, AMODE_NONE, 16'hABCD, 16'h0, 64'h5B, 4'b1000);
    frame(KIND_CMD, 2'h0, AMODE_NONE, AMODE_SHORT, 16'h0, 16'hABCD, 64'h0, 4'b1000);
    host.wr(OFS_UNIT_CFG, 8'h02);
    frame(KIND_CMD, 2'h0, AMODE_NONE, AMODE_SHORT, 16'h0, 16'hABCD, 64'h0, 4'b1101);
    frame(KIND_DATA, 2'h0, AMODE_NONE, AMODE_NONE, 16'h0, 16'hABCD, 64'h0, 4'b1000);
  endtask : t_units
  task automatic t_global;
    host.wr(OFS_KIND_MASK, 8'h0F);
    frame(KIND_ACK, 2'h0, AMODE_SHORT, AMODE_NONE, 16'hABCD, 16'h0, 64'h1234, 4'b1000);
    host.wr(OFS_KIND_MASK, 8'h0D);
    dsh(2'h0, 16'hABCD, 64'h1234, 4'b1000);
    host.wr(OFS_KIND_MASK, 8'h2B);
    dsh(2'h2, 16'hABCD, 64'h1234, 4'b1000);
    host.wr(OFS_VER_MASK, 8'h07);
    dsh(2'h2, 16'hABCD, 64'h1234, 4'b1111);
    frame(3'h5, 2'h0, AMODE_SHORT, AMODE_NONE, 16'hABCD, 16'h0, 64'h1234, 4'b1011);
    host.wr(OFS_UNIT_CFG, 8'h22);
    frame(3'h5, 2'h0, AMODE_SHORT, AMODE_NONE, 16'hABCD, 16'h0, 64'h1234, 4'b1111);
  endtask : t_global
  task automatic t_promisc;
    host.wr(OFS_FILT_CTL, 8'h05);
    dsh(2'h0, 16'h1111, 64'h1234, 4'b1001);
    host.wr(OFS_FILT_CTL, 8'h00);
    dsh(2'h0, 16'h1111, 64'h1234, 4'b1001);
  endtask : t_promisc
  task automatic t_tx;
    txf(6, 1'b0, 1'b1);
    txf(5, 1'b1, 1'b1);
    txf(3, 1'b1, 1'b1);
    txf(4, 1'b0, 1'b1);
    txf(2, 1'b1, 1'b1);
    txf(6, 1'b0, 1'b0);
  endtask : t_tx
  initial begin
    #100us;
    n_fail++;
    print_verdict;
  end
  initial begin
    repeat (10) @(negedge clk_sys);
    rst = 1'b0;
    t_reset;
    t_phy;
    t_level1;
    t_units;
    t_global;
    t_promisc;
    t_tx;
    print_verdict;
  end
endmodule : tb_top
